// >>> hw/hvw_pkg.sv
// Package for the high-voltage wake input block: map, fields, codes, timing
package hvw_pkg;

    // Pin group
    localparam int HVW_NPIN       = 5;
    localparam int HVW_NPULL      = 4;
    localparam int HVW_SYNC_PIN   = 3;

    // Clock and filter timing
    localparam int HVW_CLK_MHZ    = 20;
    localparam int HVW_FILT_SHORT_NS = 16000;
    localparam int HVW_FILT_LONG_NS  = 64000;
    localparam int HVW_FILT_SHORT_CYC_I = (HVW_FILT_SHORT_NS * HVW_CLK_MHZ + 999) / 1000;
    localparam int HVW_FILT_LONG_CYC_I  = (HVW_FILT_LONG_NS * HVW_CLK_MHZ + 999) / 1000;
    localparam int HVW_CNT_W      = 11;
    localparam logic [HVW_CNT_W-1:0] HVW_FILT_SHORT_CYC = HVW_CNT_W'(HVW_FILT_SHORT_CYC_I);
    localparam logic [HVW_CNT_W-1:0] HVW_FILT_LONG_CYC  = HVW_CNT_W'(HVW_FILT_LONG_CYC_I);

    // Register byte offsets
    localparam logic [7:0] HVW_ADR_CTRL = 8'h00;
    localparam logic [7:0] HVW_ADR_FILT = 8'h04;
    localparam logic [7:0] HVW_ADR_STAT = 8'h08;
    localparam logic [7:0] HVW_ADR_LVL  = 8'h0C;

    // Field layout
    localparam int HVW_CTRL_W     = 18;
    localparam int HVW_WFS_LSB    = 0;
    localparam int HVW_PULL_LSB   = 10;
    localparam int HVW_FILT_W     = 15;
    localparam int HVW_FSEL_LSB   = 0;

    // Reset values
    localparam logic [HVW_CTRL_W-1:0] HVW_CTRL_RST = 18'h00000;
    localparam logic [HVW_FILT_W-1:0] HVW_FILT_RST = 15'h0000;
    localparam logic [HVW_NPIN-1:0]   HVW_STAT_RST = 5'h00;

    // Wake function select codes
    localparam logic [1:0] HVW_WFS_OFF  = 2'h0;
    localparam logic [1:0] HVW_WFS_WAKE = 2'h1;
    localparam logic [1:0] HVW_WFS_SYNC = 2'h2;

    // Pull select codes
    localparam logic [1:0] HVW_PULL_NONE = 2'h0;
    localparam logic [1:0] HVW_PULL_DOWN = 2'h1;
    localparam logic [1:0] HVW_PULL_UP   = 2'h2;
    localparam logic [1:0] HVW_PULL_AUTO = 2'h3;

    // Filter select codes
    localparam logic [2:0] HVW_FSEL_STAT_SHORT = 3'h0;
    localparam logic [2:0] HVW_FSEL_STAT_LONG  = 3'h1;
    localparam logic [2:0] HVW_FSEL_CYC_SYNC   = 3'h4;

    typedef enum logic [2:0] {
        HVW_MODE_INIT,
        HVW_MODE_NORMAL,
        HVW_MODE_STOP,
        HVW_MODE_SLEEP,
        HVW_MODE_FAILSAFE,
        HVW_MODE_RESTART
    } hvw_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } hvw_wb_req_t;

endpackage

// >>> hw/hvw_wake_filter.sv
// Per-pin synchroniser and wake filter
`timescale 1ns/1ps
module hvw_wake_filter (
    // Clock, reset, enable
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    // Comparator and filter choice
    input  wire logic cmp_in,
    input  wire logic long_sel,
    // Levels and accepted edge
    output logic      sync_level,
    output logic      level,
    output logic      edge_pulse
);
    import hvw_pkg::*;

    logic                 meta_reg;
    logic                 sync_reg;
    logic                 stable_reg;
    logic                 pulse_reg;
    logic [HVW_CNT_W-1:0] cnt_reg;
    logic [HVW_CNT_W-1:0] target;

    assign target     = long_sel ? HVW_FILT_LONG_CYC : HVW_FILT_SHORT_CYC;
    assign sync_level = sync_reg;
    assign level      = stable_reg;
    assign edge_pulse = pulse_reg;

    // Two-stage synchroniser
    always_ff @(posedge clk_sys) begin // [RULE19]
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (ce) begin
            meta_reg <= cmp_in;
            sync_reg <= meta_reg;
        end
    end

    // Filter: accept a new level only after it held for the full time
    always_ff @(posedge clk_sys) begin // [RULE4] [RULE1] [RULE11]
        if (!rst_n) begin
            stable_reg <= 1'b0;
            cnt_reg    <= '0;
            pulse_reg  <= 1'b0;
        end else if (ce) begin
            pulse_reg <= 1'b0;
            if (sync_reg == stable_reg) begin
                cnt_reg <= '0;
            end else if (cnt_reg == target - HVW_CNT_W'(1)) begin // [RULE17] [RULE18]
                stable_reg <= sync_reg;
                cnt_reg    <= '0;
                pulse_reg  <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + HVW_CNT_W'(1);
            end
        end
    end

    AST_FILT_ACCEPT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
        $rose(pulse_reg) |-> (stable_reg != $past(stable_reg)) && (stable_reg == $past(sync_reg)))
        else $error("filter accepted without level change");

endmodule // hvw_wake_filter

// >>> hw/hvw_wake_inputs.sv
// High-voltage wake input block with Wishbone register slave
// Function
// RULE1: Every wake pin reports rising and falling transitions alike.
// RULE2: Accepted edge raises interrupt in Normal/Stop, wakes device in Sleep/Fail-Safe.
// RULE3: Each pin senses statically or cyclically, chosen by software.
// RULE4: Edge accepted only if level holds for the whole filter time.
// RULE5: Wake capability switched per pin by a register write.
// RULE6: Every accepted wake event latches a readable status flag.
// RULE7: Level register shows pin levels in Normal, Stop and Init.
// RULE8: Under cyclic sense the level register shows the last sampled level.
// RULE9: No level readback for the fourth pin while it serves as sync input.
// RULE10: Pull select: none, pull-down, pull-up, or automatic following level.
// RULE11: Per-pin filter select applies in static and cyclic sensing.
// RULE12: Init to Normal with static sense and high pin sets flag and interrupt.
// RULE13: Cyclic sense samples during high-side on-time; sample change is a wake.
// RULE14: Software turns the fourth pin off before choosing sync.
// RULE15: Sync code on fourth pin ignores its config and disables its wake.
// RULE16: Sleep refused, restart entered, when only wake source is cyclic sync pin.
// RULE17: Short filter time is 16 microseconds.
// RULE18: Long filter time is 64 microseconds.
// RULE19: Comparator outputs pass a two-stage synchroniser before filtering.
`timescale 1ns/1ps
module hvw_wake_inputs (
    // Clock, reset, enable
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // Wishbone slave
    input  wire hvw_pkg::hvw_wb_req_t wb_req,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Pins and high-side on-time
    input  wire logic [4:0]           wake_cmp,
    input  wire logic [4:0]           hs_on,
    // Mode controller
    input  wire hvw_pkg::hvw_mode_t   dev_mode,
    input  wire logic                 sleep_req,
    input  wire logic                 other_wake_en,
    output logic                      wake_irq,
    output logic                      wake_up,
    output logic                      sleep_ok,
    output logic                      restart_req,
    // Pull sources and sync
    output logic [3:0]                pull_up_en,
    output logic [3:0]                pull_down_en,
    output logic                      sync_out
);
    import hvw_pkg::*;

    logic [HVW_CTRL_W-1:0] ctrl_reg;
    logic [HVW_FILT_W-1:0] filt_reg;
    logic [HVW_NPIN-1:0]   stat_reg;
    logic [HVW_NPIN-1:0]   stat_next;
    logic [HVW_NPIN-1:0]   lvl_reg;
    logic [HVW_NPIN-1:0]   samp_reg;
    logic [HVW_NPIN-1:0]   hs_prev_reg;
    hvw_mode_t             mode_prev_reg;
    logic                  ack_reg;
    logic [31:0]           dat_reg;
    logic [31:0]           ctrl_wr_word;
    logic [31:0]           filt_wr_word;
    logic                  irq_reg;
    logic                  wake_reg;
    logic                  sleep_ok_reg;
    logic                  restart_reg;
    logic [3:0]            pu_reg;
    logic [3:0]            pd_reg;
    logic                  sync_reg;

    logic [HVW_NPIN-1:0]   pin_en;
    logic [HVW_NPIN-1:0]   cyc_sel;
    logic [HVW_NPIN-1:0]   sync_cyc;
    logic [HVW_NPIN-1:0]   filt_level;
    logic [HVW_NPIN-1:0]   live_level;
    logic [HVW_NPIN-1:0]   filt_edge;
    logic [HVW_NPIN-1:0]   evt;
    logic [HVW_NPIN-1:0]   clr;
    logic                  sync_sel;
    logic                  init_to_normal;
    logic                  lvl_mode;
    logic                  refuse;
    logic                  wb_req_new;
    logic                  wb_wr;

    function automatic logic [1:0] wfs_of(input logic [HVW_CTRL_W-1:0] c, input int i);
        wfs_of = c[HVW_WFS_LSB + 2*i +: 2];
    endfunction

    function automatic logic [2:0] fsel_of(input logic [HVW_FILT_W-1:0] f, input int i);
        fsel_of = f[HVW_FSEL_LSB + 3*i +: 3];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // Per-pin filters
    for (genvar g = 0; g < HVW_NPIN; g++) begin : g_pin
        hvw_wake_filter u_filt (
            .clk_sys    (clk_sys),
            .rst_n      (rst_n),
            .ce         (ce),
            .cmp_in     (wake_cmp[g]),
            .long_sel   (filt_reg[HVW_FSEL_LSB + 3*g]),
            .sync_level (live_level[g]),
            .level      (filt_level[g]),
            .edge_pulse (filt_edge[g])
        );
    end

    // Pin configuration decode
    assign sync_sel = (wfs_of(ctrl_reg, HVW_SYNC_PIN) == HVW_WFS_SYNC);

    always_comb begin
        for (int i = 0; i < HVW_NPIN; i++) begin
            pin_en[i]   = (wfs_of(ctrl_reg, i) == HVW_WFS_WAKE); // [RULE5] [RULE15]
            cyc_sel[i]  = (fsel_of(filt_reg, i) != HVW_FSEL_STAT_SHORT)
                          && (fsel_of(filt_reg, i) != HVW_FSEL_STAT_LONG); // [RULE3]
            sync_cyc[i] = (fsel_of(filt_reg, i) == HVW_FSEL_CYC_SYNC);
        end
    end

    assign init_to_normal = (mode_prev_reg == HVW_MODE_INIT) && (dev_mode == HVW_MODE_NORMAL);
    assign lvl_mode = (dev_mode == HVW_MODE_NORMAL) || (dev_mode == HVW_MODE_STOP)
                      || (dev_mode == HVW_MODE_INIT);

    // Wake events per pin
    always_comb begin
        for (int i = 0; i < HVW_NPIN; i++) begin
            evt[i] = 1'b0;
            if (pin_en[i]) begin
                if (cyc_sel[i]) begin
                    evt[i] = hs_prev_reg[i] && !hs_on[i]
                             && (filt_level[i] != samp_reg[i]); // [RULE13]
                end else begin
                    evt[i] = filt_edge[i] // [RULE1]
                             || (init_to_normal && filt_level[i]); // [RULE12]
                end
            end
        end
    end

    // Wishbone access qualifiers
    assign wb_req_new = wb_req.cyc && wb_req.stb && !ack_reg;
    assign wb_wr      = wb_req.cyc && wb_req.stb && ack_reg && wb_req.we;
    assign clr = (wb_wr && (wb_req.adr == HVW_ADR_STAT) && wb_req.sel[0])
                 ? wb_req.dat[HVW_NPIN-1:0] : '0;
    assign stat_next = (stat_reg & ~clr) | evt; // [RULE6]
    assign ctrl_wr_word = merge({14'h0000, ctrl_reg}, wb_req.dat, wb_req.sel);
    assign filt_wr_word = merge({17'h00000, filt_reg}, wb_req.dat, wb_req.sel);

    // Wishbone handshake and read data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= wb_req_new;
            if (wb_req_new) begin
                if (wb_req.adr == HVW_ADR_CTRL) begin
                    dat_reg <= {14'h0000, ctrl_reg};
                end else if (wb_req.adr == HVW_ADR_FILT) begin
                    dat_reg <= {17'h00000, filt_reg};
                end else if (wb_req.adr == HVW_ADR_STAT) begin
                    dat_reg <= {27'h0000000, stat_reg};
                end else if (wb_req.adr == HVW_ADR_LVL) begin
                    dat_reg <= {27'h0000000, lvl_reg};
                end else begin
                    dat_reg <= 32'h0000_0000;
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= HVW_CTRL_RST;
            filt_reg <= HVW_FILT_RST;
        end else if (ce && wb_wr) begin
            if (wb_req.adr == HVW_ADR_CTRL) begin
                ctrl_reg <= ctrl_wr_word[HVW_CTRL_W-1:0]; // [RULE5]
            end else if (wb_req.adr == HVW_ADR_FILT) begin
                filt_reg <= filt_wr_word[HVW_FILT_W-1:0]; // [RULE11]
            end
        end
    end

    // Wake status, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_reg <= HVW_STAT_RST;
        end else if (ce) begin
            stat_reg <= stat_next; // [RULE6]
        end
    end

    // Cyclic sampling at the end of high-side on-time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            samp_reg    <= '0;
            hs_prev_reg <= '0;
        end else if (ce) begin
            hs_prev_reg <= hs_on;
            for (int i = 0; i < HVW_NPIN; i++) begin
                if (cyc_sel[i] && hs_prev_reg[i] && !hs_on[i]) begin
                    samp_reg[i] <= filt_level[i]; // [RULE13]
                end
            end
        end
    end

    // Level status
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lvl_reg <= '0;
        end else if (ce && lvl_mode) begin // [RULE7]
            for (int i = 0; i < HVW_NPIN; i++) begin
                lvl_reg[i] <= cyc_sel[i] ? samp_reg[i] : live_level[i]; // [RULE8]
            end
            if (sync_sel) begin
                lvl_reg[HVW_SYNC_PIN] <= 1'b0; // [RULE9]
            end
        end
    end

    // Interrupt or wake signalling
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_reg       <= 1'b0;
            wake_reg      <= 1'b0;
            mode_prev_reg <= HVW_MODE_INIT;
        end else if (ce) begin
            mode_prev_reg <= dev_mode;
            irq_reg  <= (|evt) && ((dev_mode == HVW_MODE_NORMAL)
                                   || (dev_mode == HVW_MODE_STOP)); // [RULE2]
            wake_reg <= (|evt) && ((dev_mode == HVW_MODE_SLEEP)
                                   || (dev_mode == HVW_MODE_FAILSAFE)); // [RULE2]
        end
    end

    // Sleep request check
    assign refuse = !other_wake_en && (|(pin_en & sync_cyc))
                    && !(|(pin_en & ~sync_cyc)); // [RULE16]

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sleep_ok_reg <= 1'b0;
            restart_reg  <= 1'b0;
        end else if (ce) begin
            sleep_ok_reg <= sleep_req && !refuse;
            restart_reg  <= sleep_req && refuse; // [RULE16]
        end
    end

    // Pull sources and sync output
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pu_reg   <= '0;
            pd_reg   <= '0;
            sync_reg <= 1'b0;
        end else if (ce) begin
            sync_reg <= sync_sel && live_level[HVW_SYNC_PIN]; // [RULE15]
            for (int i = 0; i < HVW_NPULL; i++) begin
                case (ctrl_reg[HVW_PULL_LSB + 2*i +: 2]) // [RULE10]
                    HVW_PULL_DOWN: begin
                        pu_reg[i] <= 1'b0;
                        pd_reg[i] <= 1'b1;
                    end
                    HVW_PULL_UP: begin
                        pu_reg[i] <= 1'b1;
                        pd_reg[i] <= 1'b0;
                    end
                    HVW_PULL_AUTO: begin
                        pu_reg[i] <= filt_level[i];
                        pd_reg[i] <= !filt_level[i];
                    end
                    default: begin
                        pu_reg[i] <= 1'b0;
                        pd_reg[i] <= 1'b0;
                    end
                endcase
                if (i == HVW_SYNC_PIN && sync_sel) begin
                    pu_reg[i] <= 1'b0; // [RULE15]
                    pd_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = dat_reg;
    assign wake_irq     = irq_reg;
    assign wake_up      = wake_reg;
    assign sleep_ok     = sleep_ok_reg;
    assign restart_req  = restart_reg;
    assign pull_up_en   = pu_reg;
    assign pull_down_en = pd_reg;
    assign sync_out     = sync_reg;

    // Checks
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE6]
        (ce && (|evt)) |=> ((stat_reg & $past(evt)) == $past(evt)))
        else $error("wake event lost in status");

    AST_IRQ_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        (ce && (|evt) && (dev_mode == HVW_MODE_NORMAL)) |=> (wake_irq && !wake_up))
        else $error("no interrupt for wake in normal mode");

    AST_WAKE_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        (ce && (|evt) && (dev_mode == HVW_MODE_SLEEP)) |=> (wake_up && !wake_irq))
        else $error("no wake-up for event in sleep mode");

    AST_DISABLED_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE5]
        (ce && !pin_en[0] && !stat_reg[0]) |=> !stat_reg[0])
        else $error("disabled pin set its flag");

    AST_SYNC_NO_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE15]
        (ce && sync_sel && !stat_reg[HVW_SYNC_PIN]) |=> !stat_reg[HVW_SYNC_PIN])
        else $error("sync pin produced a wake flag");

    AST_SYNC_NO_LVL: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE9]
        (ce && sync_sel && lvl_mode) |=> !lvl_reg[HVW_SYNC_PIN])
        else $error("level shown for sync pin");

    AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE16]
        (ce && sleep_req && refuse) |=> (restart_req && !sleep_ok))
        else $error("sleep not refused");

    AST_INIT_NORMAL: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE12]
        (ce && init_to_normal && pin_en[0] && !cyc_sel[0] && filt_level[0])
        |=> (stat_reg[0] && wake_irq))
        else $error("high pin not flagged on entry to normal");

    AST_PULL_AUTO: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE10]
        (ce && (ctrl_reg[HVW_PULL_LSB +: 2] == HVW_PULL_AUTO))
        |=> (pull_up_en[0] == $past(filt_level[0])) && (pull_down_en[0] != pull_up_en[0]))
        else $error("automatic pull does not follow level");

    AST_LVL_CYCLIC: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
        (ce && cyc_sel[0] && lvl_mode) |=> (lvl_reg[0] == $past(samp_reg[0])))
        else $error("cyclic level not the sampled value");

endmodule // hvw_wake_inputs

// >>> verif/hvw_pin_model.sv
// Switches and sensor lines on the wake pins, with pull sources applied
`timescale 1ns/1ps
module hvw_pin_model (
    // Clock
    input  wire logic       clk_sys,
    // Switch state: driven or open, and driven level
    input  wire logic [4:0] sw_drive,
    input  wire logic [4:0] sw_level,
    // Pull sources from the block
    input  wire logic [3:0] pull_up_en,
    input  wire logic [3:0] pull_down_en,
    // Comparator outputs
    output logic      [4:0] wake_cmp
);
    logic [4:0] float_reg = 5'h0A;

    // Open pin 0-3 without a pull wanders every cycle; open pin 4 reads high
    always @(posedge clk_sys) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (sw_drive[i]) begin
                wake_cmp[i] = sw_level[i];
            end else if (i == 4) begin
                wake_cmp[i] = 1'b1;
            end else if (pull_up_en[i] && !pull_down_en[i]) begin
                wake_cmp[i] = 1'b1;
            end else if (pull_down_en[i] && !pull_up_en[i]) begin
                wake_cmp[i] = 1'b0;
            end else begin
                wake_cmp[i] = float_reg[i];
            end
        end
    end
endmodule // hvw_pin_model

// >>> verif/hvw_wake_inputs_bench.sv
// Self-checking bench for the wake input block
`timescale 1ns/1ps
module hvw_wake_inputs_bench;
    import hvw_pkg::*;
    localparam int S = HVW_FILT_SHORT_CYC_I;
    localparam int L = HVW_FILT_LONG_CYC_I;
    logic        clk_sys, rst_n;
    hvw_wb_req_t wb_req;
    logic [31:0] wb_dat_o, q;
    logic        wb_ack_o, sleep_req, other_wake_en;
    logic        wake_irq, wake_up, sleep_ok, restart_req, sync_out;
    logic [4:0]  wake_cmp, hs_on, sw_drive, sw_level;
    logic [3:0]  pull_up_en, pull_down_en, pulses;
    hvw_mode_t   dev_mode;
    int          errors = 0, checked = 0, irq_n = 0, c, n0;

    assign pulses = {restart_req, sleep_ok, wake_up, wake_irq};

    hvw_wake_inputs hvw_wake_inputs_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_cmp(wake_cmp),
        .hs_on(hs_on), .dev_mode(dev_mode), .sleep_req(sleep_req),
        .other_wake_en(other_wake_en), .wake_irq(wake_irq), .wake_up(wake_up),
        .sleep_ok(sleep_ok), .restart_req(restart_req), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .sync_out(sync_out));

    hvw_pin_model hvw_pin_model_i (.clk_sys(clk_sys), .sw_drive(sw_drive),
        .sw_level(sw_level), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .wake_cmp(wake_cmp));

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (wake_irq === 1'b1) irq_n <= irq_n + 1;
    end

    task end_sim;
        begin
            $display("checked=%0d errors=%0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp) begin
                errors++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
            do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 20);
            if (n >= 20) errors++;
            q = wb_dat_o;
            wb_req <= '0;
            @(posedge clk_sys);
        end
    endtask

    task setup(input logic [31:0] ctl, input logic [31:0] flt);
        begin
            wb(1'b1, HVW_ADR_CTRL, ctl);
            wb(1'b1, HVW_ADR_FILT, flt);
            wb(1'b1, HVW_ADR_STAT, 32'h0000001F);
            n0 = irq_n;
        end
    endtask

    task pin(input int i, input logic v);
        begin
            sw_drive[i] <= 1'b1;
            sw_level[i] <= v;
        end
    endtask

    task wait_p(input int b, input int mx);
        begin
            c = 0;
            do begin @(posedge clk_sys); c++; end while (pulses[b] !== 1'b1 && c < mx);
        end
    endtask

    task t_reset;
        begin
            for (int k = 0; k < 5; k++) begin
                wb(1'b0, 8'(k * 4), 32'h0);
                chk(q, 32'h0);
            end
            chk({pull_up_en, pull_down_en}, 32'h0);
        end
    endtask

    task t_edge;
        begin
            setup(32'h1, 32'h0);
            pin(0, 1'b1);
            wait_p(0, 400);
            chk(c >= S && c <= S + 6, 1'b1);
            wb(1'b0, HVW_ADR_STAT, 32'h0);
            chk(q, 32'h1);
            wb(1'b0, HVW_ADR_LVL, 32'h0);
            chk(q[0], 1'b1);
            dev_mode <= HVW_MODE_STOP;
            pin(0, 1'b0);
            wait_p(0, 400);
            chk(c >= S && c <= S + 6, 1'b1);
            dev_mode <= HVW_MODE_NORMAL;
        end
    endtask

    task t_bounce_off;
        begin
            setup(32'h1, 32'h0);
            pin(0, 1'b1);
            repeat (100) @(posedge clk_sys);
            pin(0, 1'b0);
            pin(2, 1'b1);
            repeat (400) @(posedge clk_sys);
            chk(irq_n, n0);
            wb(1'b0, HVW_ADR_STAT, 32'h0);
            chk(q, 32'h0);
            pin(2, 1'b0);
        end
    endtask

    task t_long_sleep;
        begin
            setup(32'h4, 32'h8);
            pin(1, 1'b1);
            wait_p(0, 1400);
            chk(c >= L && c <= L + 6, 1'b1);
            pin(1, 1'b0);
            setup(32'h1, 32'h0);
            dev_mode <= HVW_MODE_SLEEP;
            pin(0, 1'b1);
            wait_p(1, 400);
            chk(c < 400, 1'b1);
            chk(irq_n, n0);
            dev_mode <= HVW_MODE_FAILSAFE;
            pin(0, 1'b0);
            wait_p(1, 400);
            chk(c < 400, 1'b1);
            chk(irq_n, n0);
            dev_mode <= HVW_MODE_NORMAL;
        end
    endtask

    task t_pull;
        logic [1:0] exp [4];
        begin
            exp = '{2'b00, 2'b01, 2'b10, 2'b01};
            for (int k = 0; k < 4; k++) begin
                wb(1'b1, HVW_ADR_CTRL, 32'(k) << 10);
                repeat (2) @(posedge clk_sys);
                chk({pull_up_en[0], pull_down_en[0]}, exp[k]);
            end
            pin(0, 1'b1);
            repeat (400) @(posedge clk_sys);
            sw_drive[0] <= 1'b0;
            repeat (400) @(posedge clk_sys);
            chk({pull_up_en[0], pull_down_en[0]}, 2'b10);
            pin(0, 1'b0);
        end
    endtask

    task t_sync;
        begin
            setup(32'h0, 32'h0);
            wb(1'b1, HVW_ADR_CTRL, 32'h20080);
            pin(3, 1'b1);
            repeat (8) @(posedge clk_sys);
            chk(sync_out, 1'b1);
            repeat (400) @(posedge clk_sys);
            chk(irq_n, n0);
            chk(pull_up_en[3], 1'b0);
            wb(1'b0, HVW_ADR_LVL, 32'h0);
            chk(q[3], 1'b0);
            pin(3, 1'b0);
            repeat (8) @(posedge clk_sys);
            chk(sync_out, 1'b0);
        end
    endtask

    task t_restart;
        begin
            setup(32'h1, 32'h4);
            for (int k = 0; k < 2; k++) begin
                other_wake_en <= k[0];
                sleep_req <= 1'b1;
                @(posedge clk_sys);
                sleep_req <= 1'b0;
                wait_p(3 - k, 4);
                chk(c, 1);
            end
            other_wake_en <= 1'b0;
        end
    endtask

    task t_cyclic;
        begin
            setup(32'h4, 32'h10);
            pin(1, 1'b1);
            repeat (400) @(posedge clk_sys);
            chk(irq_n, n0);
            wb(1'b0, HVW_ADR_LVL, 32'h0);
            chk(q[1], 1'b0);
            hs_on[1] <= 1'b1;
            repeat (400) @(posedge clk_sys);
            hs_on[1] <= 1'b0;
            wait_p(0, 8);
            chk(c < 8, 1'b1);
            pin(1, 1'b0);
            repeat (400) @(posedge clk_sys);
            wb(1'b0, HVW_ADR_LVL, 32'h0);
            chk(q[1], 1'b1);
        end
    endtask

    task t_init;
        begin
            dev_mode <= HVW_MODE_INIT;
            pin(0, 1'b1);
            setup(32'h1, 32'h0);
            repeat (400) @(posedge clk_sys);
            wb(1'b1, HVW_ADR_STAT, 32'h0000001F);
            dev_mode <= HVW_MODE_NORMAL;
            wait_p(0, 6);
            chk(c < 6, 1'b1);
            wb(1'b0, HVW_ADR_STAT, 32'h0);
            chk(q[0], 1'b1);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        wb_req = '0;
        hs_on = 5'h00;
        dev_mode = HVW_MODE_NORMAL;
        sleep_req = 1'b0;
        other_wake_en = 1'b0;
        sw_drive = 5'h1F;
        sw_level = 5'h00;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_edge;
        t_bounce_off;
        t_long_sleep;
        t_pull;
        t_sync;
        t_restart;
        t_cyclic;
        t_init;
        end_sim;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        end_sim;
    end
endmodule // hvw_wake_inputs_bench
